// ===== sac_ctrl.sv
// Purpose: control and output side of a 12-bit SAR converter
// Assumes: comparator output and start line are asynchronous pins
// Notes: results also leave on link_clk through a small buffer
`timescale 1ns/1ps

// Function
// - Start high resets; falling start begins conversion
// - 12-bit parallel word held until the next result is complete, through any start
// - Twelve-bit result, 4096 codes
// - Unipolar word is straight binary
// - Bipolar word is offset binary
// - Complemented MSB output gives two's complement
// - Serial NRZ decisions, MSB first, during conversion
// - Serial code matches parallel straight/offset binary
// - End-of-conversion low once result complete and taken by the buffer
// - End-of-conversion high in reset and conversion
// - Gated negative clock pulses during conversion only
// - Conversion within 8.0 or 4.0 us
// - Fast grade converts within 2.0 us
// - Fast grade sustains 500,000 conversions per second
module sac_ctrl #(
   parameter sac_pkg::sac_grade_e SPEED_GRADE = sac_pkg::GRADE_2US
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic start_conv,
   input wire logic comp_in,
   output logic [11:0] dac_code,
   output logic eoc,
   output logic [11:0] par_word,
   output logic msb_n,
   output logic ser_data,
   output logic clk_out_n,
   output logic res_valid,
   output logic [11:0] res_word,
   input wire logic res_ready
);
   // ==========================================
   // Declarations

   // Cycles per decided bit for this grade
   localparam logic [3:0] BIT_CYC =
      sac_pkg::bit_period(SPEED_GRADE);
   // First period is one shorter: the MSB trial settles in hold
   localparam logic [3:0] FIRST_CYC = BIT_CYC - 4'h2;
   localparam logic [3:0] NEXT_CYC = BIT_CYC - 4'h1;
   localparam logic [3:0] TOP_BIT = 4'(sac_pkg::RES_BITS - 1);

   // Pin synchronisers
   logic start_m; // First stage, read only by start_s
   logic start_s; // Start level, safe to use
   logic comp_m; // First stage, read only by comp_s
   logic comp_s; // Comparator verdict, safe to use

   // Sequencer
   sac_pkg::sac_state_e state;
   logic [3:0] step_cnt; // Cycles left in the bit period
   logic [3:0] bit_idx; // Bit under trial
   logic [11:0] next_word; // Word after this decision
   logic decide; // A bit is decided this cycle
   logic last_dec; // The LSB is decided this cycle

   // Buffer hand-off
   logic push_valid; // Result offered to the buffer
   logic push_ready; // Buffer has room
   logic push; // Result taken this cycle
   logic [11:0] push_data;

   // Link domain
   logic link_rst_m; // First stage, read only by link_rstn
   logic link_rstn;
   logic fifo_rvalid;
   logic fifo_rready;
   logic [11:0] fifo_rdata;

   // ==========================================
   // Input synchronisers

   // Both pins pass two flops before any logic looks at them
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         start_m <= 1'b0;
         start_s <= 1'b0;
         comp_m <= 1'b0;
         comp_s <= 1'b0;
      end else begin
         start_m <= start_conv;
         start_s <= start_m;
         comp_m <= comp_in;
         comp_s <= comp_m;
      end
   end

   // ==========================================
   // Decision terms

   // A decision falls on the last cycle of each bit period
   assign decide = (state == sac_pkg::ST_CONV) && (step_cnt == 4'h0)
      && !start_s;
   assign last_dec = decide && (bit_idx == 4'h0);

   // Keep or drop the bit under trial, then try the next one down
   always_comb begin
      next_word = dac_code;
      if (!comp_s) begin
         next_word[bit_idx] = 1'b0;
      end
      if (bit_idx != 4'h0) begin
         next_word[bit_idx - 4'h1] = 1'b1;
      end
   end

   // ==========================================
   // Buffer offer

   // The word is offered on the LSB decision, or again while
   // waiting for room; a start withdraws it at once
   assign push_valid = (last_dec || (state == sac_pkg::ST_PUSH))
      && !start_s;
   assign push = push_valid && push_ready;
   assign push_data = last_dec ? next_word : dac_code;

   // ==========================================
   // Sequencer state

   // Start high forces hold from any state, so a running
   // conversion is simply dropped
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= sac_pkg::ST_IDLE;
      end else begin
         case (state)
            sac_pkg::ST_IDLE: begin
               // Idle until a start pulse
               if (start_s) state <= sac_pkg::ST_HOLD;
            end
            sac_pkg::ST_HOLD: begin
               // Held in reset while start stays high
               if (!start_s) state <= sac_pkg::ST_CONV;
            end
            sac_pkg::ST_CONV: begin
               if (start_s) begin
                  state <= sac_pkg::ST_HOLD;
               end else if (last_dec && push_ready) begin
                  state <= sac_pkg::ST_IDLE;
               end else if (last_dec) begin
                  // Buffer full: wait rather than lose the word
                  state <= sac_pkg::ST_PUSH;
               end
            end
            sac_pkg::ST_PUSH: begin
               if (start_s) begin
                  state <= sac_pkg::ST_HOLD;
               end else if (push_ready) begin
                  state <= sac_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= sac_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Successive approximation register

   // While start is high the MSB trial is already on the DAC, so
   // the comparator settles during the pulse itself. This only
   // holds for pulses of the documented least width; a shorter
   // one lets it settle in hold, still a full bit period before the MSB decision.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dac_code <= sac_pkg::WORD_RST;
         bit_idx <= TOP_BIT;
         step_cnt <= FIRST_CYC;
      end else if (start_s) begin
         dac_code <= sac_pkg::MSB_TRIAL;
         bit_idx <= TOP_BIT;
         step_cnt <= FIRST_CYC;
      end else if (decide) begin
         // Twelve trials from MSB down, one per bit period
         dac_code <= next_word;
         step_cnt <= NEXT_CYC;
         if (bit_idx != 4'h0) begin
            bit_idx <= bit_idx - 4'h1;
         end
      end else if (state == sac_pkg::ST_CONV) begin
         step_cnt <= step_cnt - 4'h1;
      end
   end

   // ==========================================
   // Status and parallel word

   // Status stays high from reset and every start until the
   // word is both complete and taken by the buffer
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         eoc <= sac_pkg::EOC_RST;
      end else if (start_s) begin
         eoc <= 1'b1;
      end else if (push) begin
         eoc <= 1'b0;
      end
   end

   // The word changes only when a new result is complete, so it
   // is stable from one completed result to the next. Its bits are
   // the comparator's own verdicts: straight binary on the
   // unipolar ladder, offset binary on the offset ladder.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         par_word <= sac_pkg::WORD_RST;
         msb_n <= 1'b1;
      end else if (push) begin
         par_word <= push_data;
         // Swapped in for the MSB, this gives two's complement
         msb_n <= ~push_data[11];
      end
   end

   // ==========================================
   // Serial data and clock out

   // Each verdict leaves at once in NRZ form, MSB first, framed
   // by a one-cycle low pulse on the clock output. The pulse
   // train is gated: no pulse outside a conversion.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ser_data <= 1'b0;
         clk_out_n <= sac_pkg::CLK_IDLE;
      end else if (decide) begin
         ser_data <= comp_s;
         clk_out_n <= 1'b0;
      end else begin
         clk_out_n <= sac_pkg::CLK_IDLE;
      end
   end

   // ==========================================
   // Result buffer across to the link clock

   // Two entries ride out a short stall on the link side
   sac_xfifo #(
      .W(sac_pkg::RES_BITS),
      .AW(1)
   ) u_buf (
      .wr_clk(sys_clk),
      .wr_rstn(resetn),
      .wr_valid(push_valid),
      .wr_ready(push_ready),
      .wr_data(push_data),
      .rd_clk(link_clk),
      .rd_rstn(link_rstn),
      .rd_valid(fifo_rvalid),
      .rd_ready(fifo_rready),
      .rd_data(fifo_rdata)
   );

   // ==========================================
   // Link domain

   // Reset enters the link domain at once, leaves on link_clk
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         link_rst_m <= 1'b0;
         link_rstn <= 1'b0;
      end else begin
         link_rst_m <= 1'b1;
         link_rstn <= link_rst_m;
      end
   end

   // Output stage keeps the link outputs straight from flops;
   // it refills in the cycle that the receiver takes a word
   assign fifo_rready = !res_valid || res_ready;

   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         res_valid <= 1'b0;
         res_word <= sac_pkg::WORD_RST;
      end else if (fifo_rready) begin
         res_valid <= fifo_rvalid;
         if (fifo_rvalid) begin
            res_word <= fifo_rdata;
         end
      end
   end
endmodule

// ===== sac_ctrl_monitor.sv
// Purpose: protocol checker for the conversion controller ports
// Assumes: 8, 4 or 2 us grade given through SPEED_GRADE
// Notes: bound to sac_ctrl from the testbench file
`timescale 1ns/1ps
module sac_ctrl_monitor #(
   parameter sac_pkg::sac_grade_e SPEED_GRADE = sac_pkg::GRADE_2US
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic start_conv,
   input wire logic comp_in,
   input wire logic [11:0] dac_code,
   input wire logic eoc,
   input wire logic [11:0] par_word,
   input wire logic msb_n,
   input wire logic ser_data,
   input wire logic clk_out_n,
   input wire logic res_valid,
   input wire logic [11:0] res_word,
   input wire logic res_ready
);
   // ==========================================
   // Pulse counter
   // Start history; the pin crosses a two-stage synchroniser, so an old
   // pulse may still show two cycles after start is dropped
   logic [1:0] start_seen;
   logic [3:0] pulse_cnt;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) start_seen <= 2'b00;
      else start_seen <= {start_seen[0], start_conv};
   end
   // Clock pulses since the last start
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) pulse_cnt <= 4'h0;
      else if (start_conv || start_seen != 2'b00) pulse_cnt <= 4'h0;
      else if (!clk_out_n) pulse_cnt <= pulse_cnt + 4'h1;
   end
   // ==========================================
   // Properties
   property p_start_holds_reset;
      @(posedge sys_clk) disable iff (!resetn)
      start_conv [*4] |-> eoc && clk_out_n && dac_code == sac_pkg::MSB_TRIAL;
   endproperty
   a_start_holds_reset: assert property (p_start_holds_reset)
      else $error("status or trial wrong while start held high");
   property p_clk_pulse_short;
      @(posedge sys_clk) disable iff (!resetn)
      !clk_out_n |=> clk_out_n [*2];
   endproperty
   a_clk_pulse_short: assert property (p_clk_pulse_short)
      else $error("clock output low pulse too long");
   property p_twelve_steps;
      @(posedge sys_clk) disable iff (!resetn)
      $fell(eoc) |-> (pulse_cnt + {3'b000, !clk_out_n}) == 4'd12;
   endproperty
   a_twelve_steps: assert property (p_twelve_steps)
      else $error("status fell without twelve clock pulses");
   property p_word_held;
      @(posedge sys_clk) disable iff (!resetn)
      !$stable(par_word) |-> $fell(eoc);
   endproperty
   a_word_held: assert property (p_word_held)
      else $error("parallel word changed outside completion");
   property p_msb_out;
      @(posedge sys_clk) disable iff (!resetn)
      msb_n == !par_word[11];
   endproperty
   a_msb_out: assert property (p_msb_out)
      else $error("complemented msb output wrong");
   property p_fast_time;
      @(posedge sys_clk) disable iff (!resetn)
      SPEED_GRADE == sac_pkg::GRADE_2US && $fell(start_conv) && !res_valid
      |-> ##[1:40] (!eoc || start_conv);
   endproperty
   a_fast_time: assert property (p_fast_time)
      else $error("conversion longer than forty cycles");
   property p_eoc_stays_low;
      @(posedge sys_clk) disable iff (!resetn)
      // A start seen up to two edges back still raises the status
      !eoc && !start_conv && start_seen == 2'b00 |=> !eoc;
   endproperty
   a_eoc_stays_low: assert property (p_eoc_stays_low)
      else $error("status rose without a start");
   property p_ser_with_pulse;
      @(posedge sys_clk) disable iff (!resetn)
      !$stable(ser_data) |-> !clk_out_n;
   endproperty
   a_ser_with_pulse: assert property (p_ser_with_pulse)
      else $error("serial data moved without a clock pulse");
   property p_link_hold;
      @(posedge link_clk) disable iff (!resetn)
      res_valid && !res_ready |=> res_valid && $stable(res_word);
   endproperty
   a_link_hold: assert property (p_link_hold)
      else $error("link word dropped while stalled");
endmodule

// ===== sac_host_model.sv
// Purpose: far side model: analog comparator and result sink
// Assumes: vin is the analog level as a 12-bit code
// Notes: hold_off stalls the link; taken words kept in a ring of 16
`timescale 1ns/1ps
module sac_host_model (
   input wire logic link_clk,
   input wire logic resetn,
   input wire logic [11:0] vin,
   input wire logic [11:0] dac_code,
   output logic comp_in,
   input wire logic hold_off,
   input wire logic res_valid,
   input wire logic [11:0] res_word,
   output logic res_ready,
   output int got_count
);
   // Taken words, indexed by arrival order
   logic [11:0] got [0:15];
   // Ideal comparator: keeps the trial bit while input is at or above it
   assign comp_in = (vin >= dac_code);
   // Ready changes just after a link edge, never mid-cycle
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) res_ready <= 1'b0;
      else res_ready <= !hold_off;
   end
   // Count words as they are taken
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) got_count <= 0;
      else if (res_valid && res_ready) got_count <= got_count + 1;
   end
   // Store words; no reset, the ring is read only where counted
   always_ff @(posedge link_clk) begin
      if (resetn && res_valid && res_ready) got[got_count[3:0]] <= res_word;
   end
endmodule

// ===== sac_pkg.sv
// Purpose: shared constants and types of the conversion controller
// Assumes: sys_clk runs at 20 MHz
// Notes: times are in ns; cycle counts derive from the clock period
package sac_pkg;
   // ==========================================
   // Resolution and reset values
   localparam int RES_BITS = 12;
   localparam int CODE_COUNT = 4096;
   localparam logic [11:0] MSB_TRIAL = 12'h800;
   localparam logic [11:0] WORD_RST = 12'h000;
   localparam logic EOC_RST = 1'b1;
   localparam logic CLK_IDLE = 1'b1;
   // ==========================================
   // Timing
   localparam int SYS_PERIOD_NS = 50;
   localparam int START_MIN_NS = 100;
   localparam int START_MIN_CYC =
      (START_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CONV_SLOW_NS = 8000;
   localparam int CONV_MID_NS = 4000;
   localparam int CONV_FAST_NS = 2000;
   localparam int CONV_SLOW_CYC = CONV_SLOW_NS / SYS_PERIOD_NS;
   localparam int CONV_MID_CYC = CONV_MID_NS / SYS_PERIOD_NS;
   localparam int CONV_FAST_CYC = CONV_FAST_NS / SYS_PERIOD_NS;
   localparam int RATE_MAX_HZ = 500000;
   localparam int MIN_PERIOD_NS = 1000000000 / RATE_MAX_HZ;
   // Least bit period: trial, two sync stages, decision
   localparam int SYNC_CYC = 3;
   // ==========================================
   // Types
   typedef enum logic [1:0] {
      GRADE_8US = 2'b00,
      GRADE_4US = 2'b01,
      GRADE_2US = 2'b10
   } sac_grade_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01,
      ST_CONV = 2'b10,
      ST_PUSH = 2'b11
   } sac_state_e;
   // ==========================================
   // Cycles per decided bit for a speed grade
   function automatic logic [3:0] bit_period(sac_grade_e g);
      int cyc;
      case (g)
         GRADE_8US: cyc = CONV_SLOW_CYC / RES_BITS;
         GRADE_4US: cyc = CONV_MID_CYC / RES_BITS;
         default: cyc = CONV_FAST_CYC / RES_BITS;
      endcase
      if (cyc < SYNC_CYC) cyc = SYNC_CYC;
      return cyc[3:0];
   endfunction
endpackage

// ===== sac_xfifo.sv
// Purpose: two-clock result buffer with gray-coded pointers
// Assumes: each reset releases in step with its own clock
// Notes: depth is two to the power AW
`timescale 1ns/1ps
module sac_xfifo #(
   parameter int W = 12,
   parameter int AW = 1
) (
   input wire logic wr_clk,
   input wire logic wr_rstn,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [W-1:0] wr_data,
   input wire logic rd_clk,
   input wire logic rd_rstn,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [W-1:0] rd_data
);
   localparam int DEPTH = 2 ** AW;
   localparam logic [AW:0] PTR_ONE = (AW + 1)'(1);
   localparam logic [AW:0] FULL_GAP = PTR_ONE << AW;

   logic [W-1:0] mem [0:DEPTH-1]; // Storage, no reset needed
   logic [AW:0] wbin, wgray, rbin, rgray;
   logic [AW:0] rg_m, rg_s; // Read pointer seen by writer
   logic [AW:0] wg_m, wg_s; // Write pointer seen by reader

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [AW:0] to_bin(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--) b[i] = b[i+1] ^ g[i];
      return b;
   endfunction

   // ==========================================
   // Write side
   // Full when the writer is one lap ahead; a stale read pointer
   // only makes full last longer, never lets a word be lost
   assign wr_ready = (wbin ^ to_bin(rg_s)) != FULL_GAP;

   always_ff @(posedge wr_clk) begin
      if (wr_valid && wr_ready) mem[wbin[AW-1:0]] <= wr_data;
   end

   always_ff @(posedge wr_clk or negedge wr_rstn) begin
      if (!wr_rstn) begin
         wbin <= '0;
         wgray <= '0;
      end else if (wr_valid && wr_ready) begin
         wbin <= wbin + PTR_ONE;
         wgray <= to_gray(wbin + PTR_ONE);
      end
   end

   // Read pointer into the write domain
   always_ff @(posedge wr_clk or negedge wr_rstn) begin
      if (!wr_rstn) begin
         rg_m <= '0;
         rg_s <= '0;
      end else begin
         rg_m <= rgray;
         rg_s <= rg_m;
      end
   end

   // ==========================================
   // Read side
   assign rd_valid = rgray != wg_s;
   assign rd_data = mem[rbin[AW-1:0]];

   always_ff @(posedge rd_clk or negedge rd_rstn) begin
      if (!rd_rstn) begin
         rbin <= '0;
         rgray <= '0;
      end else if (rd_valid && rd_ready) begin
         rbin <= rbin + PTR_ONE;
         rgray <= to_gray(rbin + PTR_ONE);
      end
   end

   // Write pointer into the read domain
   always_ff @(posedge rd_clk or negedge rd_rstn) begin
      if (!rd_rstn) begin
         wg_m <= '0;
         wg_s <= '0;
      end else begin
         wg_m <= wgray;
         wg_s <= wg_m;
      end
   end
endmodule

// ===== sar_adc12_conversion_control_test.sv
// Purpose: self-checking bench of the conversion controller
// Assumes: fast grade, 40 cycles per conversion at 20 MHz
// Notes: host model answers the comparator and sinks link words
`timescale 1ns/1ps
module sar_adc12_conversion_control_test;
   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic resetn = 1'b0;
   logic start_conv = 1'b0;
   logic hold_off = 1'b0;
   logic [11:0] vin = 12'h000;
   logic comp_in, eoc, msb_n, ser_data, clk_out_n, res_valid, res_ready;
   logic [11:0] dac_code, par_word, res_word;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   int taken = 0;
   logic [11:0] exp_q [$];
   // ==========================================
   // Clocks, design and far side
   always #25 sys_clk = ~sys_clk;
   always #32 link_clk = ~link_clk;
   sac_ctrl #(.SPEED_GRADE(sac_pkg::GRADE_2US)) i_dut (
      .sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
      .start_conv(start_conv), .comp_in(comp_in), .dac_code(dac_code),
      .eoc(eoc), .par_word(par_word), .msb_n(msb_n), .ser_data(ser_data),
      .clk_out_n(clk_out_n), .res_valid(res_valid), .res_word(res_word),
      .res_ready(res_ready));
   sac_host_model i_host (
      .link_clk(link_clk), .resetn(resetn), .vin(vin), .dac_code(dac_code),
      .comp_in(comp_in), .hold_off(hold_off), .res_valid(res_valid),
      .res_word(res_word), .res_ready(res_ready), .got_count());
   // ==========================================
   // Compare and helper tasks
   task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: word %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: flag %b not %b", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Hold start high for hi cycles, then drop it to launch
   task automatic launch(input logic [11:0] v, input int hi);
      vin = v;
      start_conv = 1'b1;
      tick(hi);
      start_conv = 1'b0;
      // Status rises only on the third edge after start goes high
      tick(1);
      chk1(eoc, 1'b1);
   endtask
   // Follow a conversion to its end, gathering the serial verdicts
   task automatic follow(output logic [11:0] ser, output int n,
                         output int pulses);
      ser = 12'h000;
      n = 0;
      pulses = 0;
      while (eoc !== 1'b0 && n < 400) begin
         tick(1);
         n++;
         if (clk_out_n === 1'b0) begin
            ser = {ser[10:0], ser_data};
            pulses++;
         end
      end
   endtask
   // One full conversion judged on its status, clock pulses, serial, parallel and MSB outputs
   task automatic conv_check(input logic [11:0] v, input int hi);
      logic [11:0] ser;
      int n;
      int pulses;
      launch(v, hi);
      follow(ser, n, pulses);
      chk1(n <= 40, 1'b1);
      chk12(12'(pulses), 12'd12);
      chk12(ser, v);
      chk12(par_word, v);
      chk12({msb_n, par_word[10:0]}, v ^ 12'h800);
      exp_q.push_back(v);
   endtask
   // Wait for the link to hand over every word, in order
   task automatic drain_check();
      int k;
      k = 0;
      while (i_host.got_count < taken + exp_q.size() && k < 200) begin
         tick(1);
         k++;
      end
      chk12(12'(i_host.got_count), 12'(taken + exp_q.size()));
      while (exp_q.size() > 0) begin
         chk12(i_host.got[taken % 16], exp_q.pop_front());
         taken++;
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic sc_reset();
      chk1(eoc, 1'b1);
      chk1(clk_out_n, 1'b1);
      chk1(res_valid, 1'b0);
      chk12(par_word, 12'h000);
   endtask
   // Boundary codes back to back at the top rate
   task automatic sc_codes();
      logic [11:0] tbl [8];
      int t0;
      tbl = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h001, 12'haaa,
              12'h555, 12'hc00};
      t0 = cycles;
      foreach (tbl[i]) conv_check(tbl[i], 2);
      chk1((cycles - t0) <= 320, 1'b1);
      drain_check();
   endtask
   // Restart mid conversion: old word kept, aborted word dropped
   task automatic sc_abort();
      conv_check(12'h3c5, 2);
      launch(12'h9a6, 2);
      tick(15);
      chk12(par_word, 12'h3c5);
      chk1(eoc, 1'b1);
      conv_check(12'h21b, 6);
      drain_check();
   endtask
   // Far side stalls until the buffer refuses and the status waits
   task automatic sc_stall();
      logic [11:0] ser;
      int n;
      int pulses;
      hold_off = 1'b1;
      tick(4);
      conv_check(12'h111, 2);
      conv_check(12'h222, 2);
      conv_check(12'h333, 2);
      launch(12'h444, 2);
      tick(80);
      chk1(eoc, 1'b1);
      hold_off = 1'b0;
      follow(ser, n, pulses);
      chk12(par_word, 12'h444);
      exp_q.push_back(12'h444);
      drain_check();
   endtask
   // ==========================================
   // Verdict, timeout and main sequence
   task automatic results();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      tick(10);
      resetn = 1'b1;
      tick(3);
      sc_reset();
      sc_codes();
      sc_abort();
      sc_stall();
      results();
   end
endmodule
bind sac_ctrl sac_ctrl_monitor #(.SPEED_GRADE(SPEED_GRADE)) i_mon (
   .sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
   .start_conv(start_conv), .comp_in(comp_in), .dac_code(dac_code),
   .eoc(eoc), .par_word(par_word), .msb_n(msb_n), .ser_data(ser_data),
   .clk_out_n(clk_out_n), .res_valid(res_valid), .res_word(res_word),
   .res_ready(res_ready));
